// >>> core/eipu_pkg.sv
// Package for the external pin interrupt unit: offsets, layouts, resets, carriers
package eipu_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] OFS_SENSE_CTRL = 8'h60;
   localparam logic [7:0] OFS_PIN_ENABLE = 8'h61;
   localparam logic [7:0] OFS_PIN_FLAGS = 8'h62;
   localparam logic [7:0] OFS_GRP_ENABLE = 8'h63;
   localparam logic [7:0] OFS_GRP_FLAGS = 8'h64;
   localparam logic [7:0] OFS_MASK_GRP1 = 8'h6C;
   localparam logic [7:0] OFS_MASK_GRP2 = 8'h6D;
   localparam logic [7:0] OFS_MASK_GRP3 = 8'h73;

   // Sizes
   localparam int NUM_PINS = 3;
   localparam int NUM_GRPS = 4;
   localparam int GRP_W = 8;
   localparam int SENSE_W = 2;
   localparam int SENSE_BITS = 6;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_PINS = 3'h0;
   localparam logic [3:0] RST_GRPS = 4'h0;
   localparam logic [31:0] RST_WATCH = 32'h0000_0000;

   // Sense selection encodings
   localparam logic [1:0] SENSE_LOW = 2'h0;
   localparam logic [1:0] SENSE_ANY = 2'h1;
   localparam logic [1:0] SENSE_FALL = 2'h2;
   localparam logic [1:0] SENSE_RISE = 2'h3;

   // Shortest pulse that must be seen, and its clock count at 40 MHz
   localparam int CLK_PERIOD_PS = 25000;
   localparam int MIN_PULSE_NS = 50;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * 1000) / CLK_PERIOD_PS;

   // Requests and acknowledges toward the core, one bit per source
   typedef struct packed {
      logic [3:0] group;
      logic [2:0] pin;
   } eipu_src_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eipu_bus_req_t;
endpackage

// >>> core/eipu_top.sv
// External pin interrupt unit: dedicated pins, pin-change groups, flags, requests
//
// Summary of operation
// - Sense register: six sense bits, top two zero
// - Sense codes: low, any, falling, rising edge
// - Pin request needs enable bit and global enable
// - Pulses over 50 ns always caught
// - Low level requests while pin stays low
// - Sense change while enabled may raise request
// - Pins trigger even when driven as outputs
// - Selected edge sets the pin's flag
// - Flag, enable, global enable make request
// - Flags clear when core takes the vector
// - Writing one clears a flag, zero keeps
// - Level-sensed pin holds its flag at zero
// - Sleep with pin disabled may set flag
// - Four groups of eight; change sets group flag
// - Group request needs group and global enable
// - Input counts only with mask and group enable
// - Change on watched inputs wakes without clock
//
// Register map on the plain port
//   0x60  Sense control: pin n at bits 2n+1:2n, bits 7:6 read zero
//   0x61  Pin enables in bits 2:0
//   0x62  Pin flags in bits 2:0, write one to clear
//   0x63  Group enables in bits 3:0
//   0x64  Group flags in bits 3:0, write one to clear
//   0x6C  Mask for watched inputs 15:8
//   0x6D  Mask for watched inputs 23:16
//   0x73  Mask for watched inputs 31:24
//   Group zero mask arrives on a port, kept by its owner
//   Unmapped reads return zero; unmapped writes are dropped
//
// Reset
//   Asynchronous, active low, all registers to zero
//   Read data held at zero while in reset
//   Requests low in reset, since every enable is zero
//   First access allowed on the first edge after release
//
// Register port timing
//   Write lands on the edge that samples the strobe
//   Read data stand in the cycle after the strobe only
//   Read data return to zero in every other cycle
//   Strobes may follow back to back with no gap
//   The port never stalls the master
//
// Pin path
//   Pin, then two synchroniser flops, then one history flop
//   Edge seen between synchronised and history samples
//   Flag set on the third edge after the pin moves
//   Request follows the flag in the same cycle
//   Low-level sense bypasses the flag entirely
//   Level request follows the synchronised pin, two edges late
//   Flag held at zero while its pin is level sensed
//
// Group path
//   Each watched input synchronised like the pins
//   Any difference between samples counts as a change
//   Mask bit and group enable both gate a change
//   One flag per group, one request line per group
//   Changes already in flight may flag once enabled
//
// Flag priority
//   Hardware set beats a software clear in one cycle
//   Hardware set also beats a vector-taken clear
//   Reasoning: a lost event is worse than a repeat
//
// Core handshake
//   Vector-taken pulses are one cycle, one bit per source
//   Global enable gates every request line, not the flags
//   Flags keep collecting events while the core is masked
//   Which taken source goes first is the core's choice
//
// Safe sense change
//   Disable the pin first
//   Rewrite its sense bits
//   Clear its flag with a one
//   Enable it again
//
// Stopped clock
//   Wake output is combinational from the raw pins
//   Level wake: enabled pin in level mode and low
//   Edge wake: raw pin differs from its synchronised copy
//   Change wake: raw input differs from its synchronised copy
//   Wake output may glitch; the clock tree must filter it
//
// Widths
//   Three dedicated pins, two sense bits each
//   Thirty-two watched inputs in four groups of eight
//
// Limitations
//   Pulses shorter than two periods may be missed
//   A pulse inside one period may be missed entirely
//   Changing the sense of an enabled edge-sensed pin sets its flag
//   Disabled pins read low in sleep and may flag
//   No pin direction input; a driven pin still triggers
//   Group zero mask is not stored here
//   Vector placement and sleep control live elsewhere
//   Sleep only affects disabled dedicated pins
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module eipu_top (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Register port
   input wire eipu_pkg::eipu_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   // External pins
   input wire logic [2:0] i_dedicated_irq_pins,
   input wire logic [31:0] i_change_watch_inputs,
   // Lowest group mask, held outside this block
   input wire logic [7:0] i_change_mask_group0,
   // Core side
   input wire logic i_core_status_word_ie,
   input wire eipu_pkg::eipu_src_t i_vector_taken,
   input wire logic i_sleep,
   output eipu_pkg::eipu_src_t o_irq_req,
   output logic o_async_wake
);

   // Software visible state
   logic [5:0] pin_sense_control_r;
   logic [2:0] pin_irq_enable_mask_r;
   logic [2:0] dedicated_pin_flags_r;
   logic [3:0] change_group_enable_r;
   logic [3:0] change_group_flags_r;
   logic [7:0] change_mask_group1_r;
   logic [7:0] change_mask_group2_r;
   logic [7:0] change_mask_group3_r;

   // Sampling pipelines
   logic [2:0] pin_meta_r;
   logic [2:0] pin_sync_r;
   logic [2:0] pin_prev_r;
   logic [31:0] watch_meta_r;
   logic [31:0] watch_sync_r;
   logic [31:0] watch_prev_r;

   // Decode and events
   logic wr_sense;
   logic wr_pin_en;
   logic wr_pin_flag;
   logic wr_grp_en;
   logic wr_grp_flag;
   // Mask write strobes
   logic wr_mask1;
   logic wr_mask2;
   logic wr_mask3;
   logic [2:0] pin_eff;
   logic [2:0] pin_event;
   logic [2:0] sense_change;
   logic [2:0] level_mode;
   logic [2:0] pin_flags_nxt;
   logic [3:0] grp_flags_nxt;
   logic [31:0] watch_mask;
   logic [31:0] watch_enabled;
   logic [3:0] grp_event;
   logic [7:0] rdata_nxt;

   // Request and wake terms
   logic [2:0] pin_pending;
   logic [2:0] pin_ie_gate;
   logic [3:0] grp_ie_gate;
   logic wake_level;
   logic wake_edge;
   logic wake_change;

   // Write strobes per register
   assign wr_sense = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_SENSE_CTRL);
   assign wr_pin_en = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_PIN_ENABLE);
   assign wr_pin_flag = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_PIN_FLAGS);
   assign wr_grp_en = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_GRP_ENABLE);
   assign wr_grp_flag = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_GRP_FLAGS);
   assign wr_mask1 = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_MASK_GRP1);
   assign wr_mask2 = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_MASK_GRP2);
   assign wr_mask3 = i_bus.wr && (i_bus.addr == eipu_pkg::OFS_MASK_GRP3);

   // Sense control, six bits kept
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_sense_control_r <= eipu_pkg::RST_BYTE[5:0];
      end else if (wr_sense) begin
         pin_sense_control_r <= i_bus.wdata[5:0];
      end
   end

   // Enables and masks
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_irq_enable_mask_r <= eipu_pkg::RST_PINS;
         change_group_enable_r <= eipu_pkg::RST_GRPS;
         change_mask_group1_r <= eipu_pkg::RST_BYTE;
         change_mask_group2_r <= eipu_pkg::RST_BYTE;
         change_mask_group3_r <= eipu_pkg::RST_BYTE;
      end else begin
         if (wr_pin_en) begin
            pin_irq_enable_mask_r <= i_bus.wdata[2:0];
         end
         if (wr_grp_en) begin
            change_group_enable_r <= i_bus.wdata[3:0];
         end
         if (wr_mask1) begin
            change_mask_group1_r <= i_bus.wdata;
         end
         if (wr_mask2) begin
            change_mask_group2_r <= i_bus.wdata;
         end
         if (wr_mask3) begin
            change_mask_group3_r <= i_bus.wdata;
         end
      end
   end

   // Disabled pins lose their input buffer in sleep; reads as low then
   assign pin_eff = i_dedicated_irq_pins & ~(~pin_irq_enable_mask_r & {3{i_sleep}});

   // Two-flop synchroniser plus a history stage; no pin direction gating
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_meta_r <= eipu_pkg::RST_PINS;
         pin_sync_r <= eipu_pkg::RST_PINS;
         pin_prev_r <= eipu_pkg::RST_PINS;
         watch_meta_r <= eipu_pkg::RST_WATCH;
         watch_sync_r <= eipu_pkg::RST_WATCH;
         watch_prev_r <= eipu_pkg::RST_WATCH;
      end else begin
         pin_meta_r <= pin_eff;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
         watch_meta_r <= i_change_watch_inputs;
         watch_sync_r <= watch_meta_r;
         watch_prev_r <= watch_sync_r;
      end
   end

   // Edge selection per pin; any pulse over one period is sampled at least once
   always_comb begin
      for (int p = 0; p < eipu_pkg::NUM_PINS; p++) begin
         level_mode[p] = 1'b0;
         sense_change[p] = 1'b0;
         case (pin_sense_control_r[p*eipu_pkg::SENSE_W +: eipu_pkg::SENSE_W])
            eipu_pkg::SENSE_LOW: begin
               level_mode[p] = 1'b1;
               pin_event[p] = 1'b0;
            end
            eipu_pkg::SENSE_ANY: pin_event[p] = pin_sync_r[p] ^ pin_prev_r[p];
            eipu_pkg::SENSE_FALL: pin_event[p] = pin_prev_r[p] & ~pin_sync_r[p];
            eipu_pkg::SENSE_RISE: pin_event[p] = pin_sync_r[p] & ~pin_prev_r[p];
            default: pin_event[p] = 1'b0;
         endcase
         // Rewriting the sense of an enabled pin may itself trip the flag
         if (wr_sense && pin_irq_enable_mask_r[p] &&
             (i_bus.wdata[p*eipu_pkg::SENSE_W +: eipu_pkg::SENSE_W] !=
              pin_sense_control_r[p*eipu_pkg::SENSE_W +: eipu_pkg::SENSE_W])) begin
            sense_change[p] = 1'b1;
         end
      end
   end

   // Pin flags: set wins over clear, level mode forces zero
   always_comb begin
      pin_flags_nxt = dedicated_pin_flags_r;
      if (wr_pin_flag) begin
         pin_flags_nxt = pin_flags_nxt & ~i_bus.wdata[2:0];
      end
      pin_flags_nxt = pin_flags_nxt & ~i_vector_taken.pin;
      pin_flags_nxt = pin_flags_nxt | pin_event | sense_change;
      pin_flags_nxt = pin_flags_nxt & ~level_mode;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         dedicated_pin_flags_r <= eipu_pkg::RST_PINS;
      end else begin
         dedicated_pin_flags_r <= pin_flags_nxt;
      end
   end

   // Per-input enable: own mask bit and its group enable
   assign watch_mask = {change_mask_group3_r, change_mask_group2_r,
                        change_mask_group1_r, i_change_mask_group0};
   always_comb begin
      for (int g = 0; g < eipu_pkg::NUM_GRPS; g++) begin
         watch_enabled[g*eipu_pkg::GRP_W +: eipu_pkg::GRP_W] =
            watch_mask[g*eipu_pkg::GRP_W +: eipu_pkg::GRP_W] &
            {eipu_pkg::GRP_W{change_group_enable_r[g]}};
         grp_event[g] = |((watch_sync_r[g*eipu_pkg::GRP_W +: eipu_pkg::GRP_W] ^
                           watch_prev_r[g*eipu_pkg::GRP_W +: eipu_pkg::GRP_W]) &
                          watch_enabled[g*eipu_pkg::GRP_W +: eipu_pkg::GRP_W]);
      end
   end

   // Group flags: set wins over both clears
   always_comb begin
      grp_flags_nxt = change_group_flags_r;
      if (wr_grp_flag) begin
         grp_flags_nxt = grp_flags_nxt & ~i_bus.wdata[3:0];
      end
      grp_flags_nxt = (grp_flags_nxt & ~i_vector_taken.group) | grp_event;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         change_group_flags_r <= eipu_pkg::RST_GRPS;
      end else begin
         change_group_flags_r <= grp_flags_nxt;
      end
   end

   // Pending per pin: latched edge, or live low level
   assign pin_pending = dedicated_pin_flags_r | (level_mode & ~pin_sync_r);

   // Global enable spread over every source
   assign pin_ie_gate = pin_irq_enable_mask_r & {3{i_core_status_word_ie}};
   assign grp_ie_gate = change_group_enable_r & {4{i_core_status_word_ie}};

   // Requests to the core, each source its own vector line
   always_comb begin
      o_irq_req.pin = pin_pending & pin_ie_gate;
      o_irq_req.group = change_group_flags_r & grp_ie_gate;
   end

   // Level wake: enabled, level sensed, raw pin low
   assign wake_level = |(level_mode & pin_irq_enable_mask_r & ~i_dedicated_irq_pins);
   // Edge wake: raw pin ahead of its synchronised copy
   assign wake_edge = |(pin_irq_enable_mask_r & (i_dedicated_irq_pins ^ pin_sync_r) &
                        ~level_mode);
   // Change wake: watched input ahead of its copy; needs no clock
   assign wake_change = |((i_change_watch_inputs ^ watch_sync_r) & watch_enabled);

   // Clockless wake path straight from the pins, for a stopped clock
   assign o_async_wake = wake_level | wake_edge | wake_change;

   // Read mux; unmapped and reserved bits read zero
   always_comb begin
      rdata_nxt = eipu_pkg::RST_BYTE;
      case (i_bus.addr)
         eipu_pkg::OFS_SENSE_CTRL: rdata_nxt = {2'h0, pin_sense_control_r};
         eipu_pkg::OFS_PIN_ENABLE: rdata_nxt = {5'h00, pin_irq_enable_mask_r};
         eipu_pkg::OFS_PIN_FLAGS: rdata_nxt = {5'h00, dedicated_pin_flags_r};
         eipu_pkg::OFS_GRP_ENABLE: rdata_nxt = {4'h0, change_group_enable_r};
         eipu_pkg::OFS_GRP_FLAGS: rdata_nxt = {4'h0, change_group_flags_r};
         eipu_pkg::OFS_MASK_GRP1: rdata_nxt = change_mask_group1_r;
         eipu_pkg::OFS_MASK_GRP2: rdata_nxt = change_mask_group2_r;
         eipu_pkg::OFS_MASK_GRP3: rdata_nxt = change_mask_group3_r;
         default: rdata_nxt = eipu_pkg::RST_BYTE;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= eipu_pkg::RST_BYTE;
      end else if (i_bus.rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= eipu_pkg::RST_BYTE;
      end
   end

endmodule
`default_nettype wire

// >>> verification/eipu_core_model.sv
// Core model: takes the lowest pending request after a short wait
`timescale 1ns/1ps
`default_nettype none
module eipu_core_model (
   // Clock, reset, control
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_ack_en,
   // Requests in, vector taken out
   input wire eipu_pkg::eipu_src_t i_req,
   output var eipu_pkg::eipu_src_t o_taken
);
   logic [1:0] wait_r;
   // Slow core: three cycles of latency, one source taken per pulse
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_r <= 2'h0;
         o_taken <= '0;
      end else begin
         o_taken <= '0;
         wait_r <= (i_ack_en && i_req != '0 && o_taken == '0) ? wait_r + 2'h1 : 2'h0;
         if (wait_r == 2'h2) begin
            o_taken <= i_req & (~i_req + 7'h01); // Lowest first
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/eipu_monitor.sv
// Port checker for the external pin interrupt unit, with its bind
`timescale 1ns/1ps
`default_nettype none
module eipu_monitor (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Register port
   input wire eipu_pkg::eipu_bus_req_t i_bus,
   input wire logic [7:0] o_rdata,
   // Pins and core
   input wire logic [2:0] i_dedicated_irq_pins,
   input wire logic [31:0] i_change_watch_inputs,
   input wire logic [7:0] i_change_mask_group0,
   input wire logic i_core_status_word_ie,
   input wire eipu_pkg::eipu_src_t i_vector_taken,
   input wire logic i_sleep,
   input wire eipu_pkg::eipu_src_t o_irq_req,
   input wire logic o_async_wake
);
   logic [5:0] sense_r;
   logic [2:0] pen_r;
   logic [3:0] gen_r;
   logic [7:0] msk1_r;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Shadow of the controls, rebuilt from bus writes
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {sense_r, pen_r, gen_r, msk1_r} <= '0;
      end else if (i_bus.wr) begin
         case (i_bus.addr)
            eipu_pkg::OFS_SENSE_CTRL: sense_r <= i_bus.wdata[5:0];
            eipu_pkg::OFS_PIN_ENABLE: pen_r <= i_bus.wdata[2:0];
            eipu_pkg::OFS_GRP_ENABLE: gen_r <= i_bus.wdata[3:0];
            eipu_pkg::OFS_MASK_GRP1: msk1_r <= i_bus.wdata;
            default: ;
         endcase
      end
   end
   chk_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
      else $error("read data outside answer cycle");
   chk_sense_resv: assert property ($past(i_bus.rd && i_bus.addr == 8'h60) |-> o_rdata[7:6] == 2'h0)
      else $error("reserved sense bits set");
   chk_ie_gate: assert property (!i_core_status_word_ie |-> o_irq_req == 7'h00)
      else $error("request without global enable");
   chk_en_gate: assert property ((o_irq_req.pin & ~pen_r) == 3'h0 && (o_irq_req.group & ~gen_r) == 4'h0)
      else $error("request from disabled source");
   chk_level_req: assert property ((!i_dedicated_irq_pins[0])[*3] ##0 (i_core_status_word_ie
      && pen_r[0] && sense_r[1:0] == 2'h0) |-> o_irq_req.pin[0]) else $error("low level not requesting");
   chk_rise_flag: assert property ($rose(i_dedicated_irq_pins[0]) && sense_r[1:0] == 2'h3
      && pen_r[0] && i_core_status_word_ie |-> ##[1:4] o_irq_req.pin[0]) else $error("rise missed");
   chk_grp_change: assert property ($changed(i_change_watch_inputs[8]) && msk1_r[0] && gen_r[1]
      && i_core_status_word_ie |-> ##[1:4] o_irq_req.group[1]) else $error("group change missed");
   chk_vec_clear: assert property (($stable(i_change_watch_inputs))[*4] ##0 (i_vector_taken.group[1]
      && !i_bus.wr) |=> !o_irq_req.group[1]) else $error("flag kept after vector");
   chk_wake_level: assert property ((!i_dedicated_irq_pins[0] && pen_r[0]
      && sense_r[1:0] == 2'h0) |-> o_async_wake) else $error("no wake on low level");
   cover property (i_vector_taken.group != 4'h0);
   cover property (o_irq_req.pin[0] && sense_r[1:0] == 2'h0);
   cover property (o_irq_req.group[1]);
endmodule
bind eipu_top eipu_monitor u_mon (.i_ref_clk, .i_rst_n, .i_bus, .o_rdata, .i_dedicated_irq_pins,
   .i_change_watch_inputs, .i_change_mask_group0, .i_core_status_word_ie, .i_vector_taken,
   .i_sleep, .o_irq_req, .o_async_wake);
`default_nettype wire

// >>> verification/eipu_top_bench.sv
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module eipu_top_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   eipu_pkg::eipu_bus_req_t bus = '0;
   logic [7:0] rdata, d, m;
   logic [2:0] pins = 3'h7;
   logic [31:0] watch = 32'h0;
   logic [7:0] msk0 = 8'h00;
   logic [3:0] en;
   logic ie = 1'b0;
   logic ack_en = 1'b0;
   eipu_pkg::eipu_src_t req, taken;
   int n_fail = 0;
   int samples_checked = 0;
   int g, b;
   // Sense, pin en, grp en, masks 1..3, pin flags, grp flags
   logic [7:0] adr [8] = '{8'h60, 8'h61, 8'h63, 8'h6C, 8'h6D, 8'h73, 8'h62, 8'h64};
   logic [7:0] wmask [6] = '{8'h3F, 8'h07, 8'h0F, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0] wval [6];
   eipu_top DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_dedicated_irq_pins(pins), .i_change_watch_inputs(watch), .i_change_mask_group0(msk0),
      .i_core_status_word_ie(ie), .i_vector_taken(taken), .i_sleep(1'b0), .o_irq_req(req),
      .o_async_wake());
   eipu_core_model u_core (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ack_en(ack_en), .i_req(req),
      .o_taken(taken));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   function automatic logic exp_flag(input logic [1:0] md, input logic rise);
      return md == eipu_pkg::SENSE_ANY || md == (rise ? eipu_pkg::SENSE_RISE : eipu_pkg::SENSE_FALL);
   endfunction
   // Only the toggled group may flag, and only with mask and enable
   function automatic logic [7:0] exp_grp(input int gg, input int bb, input logic [7:0] mm,
      input logic [3:0] ee);
      return (mm[bb] & ee[gg]) ? (8'h01 << gg) : 8'h00;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      void'($urandom(99));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, one unmapped place too
      foreach (adr[i]) rchk(adr[i], 8'h00);
      rchk(8'h65, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wval[i] = $urandom;
         wr(adr[i], wval[i]);
      end
      for (int i = 0; i < 6; i++) rchk(adr[i], wval[i] & wmask[i]);
      for (int i = 0; i < 6; i++) wr(adr[i], 8'h00);
      $display("test registers done");
      // Every sense code on pin 0, reconfigured in the safe order
      ie <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         wr(adr[1], 8'h00);
         wr(adr[0], {6'h00, k[1:0]});
         wr(adr[6], 8'h07);
         wr(adr[1], 8'h01);
         for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            pins[0] <= e[0];
            repeat (6) @(posedge clk);
            #1 check({5'h00, req.pin}, {7'h00, exp_flag(k[1:0], e[0]) | (k == 0 && e == 0)});
            rchk(adr[6], {7'h00, exp_flag(k[1:0], e[0])});
            @(posedge clk);
            ie <= 1'b0;
            @(posedge clk);
            #1 check({1'b0, req}, 8'h00);
            @(posedge clk);
            ie <= 1'b1;
            wr(adr[6], 8'h07);
         end
      end
      $display("test sense modes done");
      // Random group, input and mask; first pass is input 8
      for (int i = 0; i < 12; i++) begin
         g = (i == 0) ? 1 : $urandom % 4;
         b = (i == 0) ? 0 : $urandom % 8;
         m = (i == 0) ? 8'hFF : 8'($urandom);
         en = (i < 3) ? 4'hF : 4'($urandom);
         @(posedge clk);
         if (g == 0) msk0 <= m;
         else wr(adr[g + 2], m);
         wr(adr[2], {4'h0, en});
         wr(adr[7], 8'h0F);
         watch[g * 8 + b] <= ~watch[g * 8 + b];
         repeat (6) @(posedge clk);
         #1 check({4'h0, req.group}, exp_grp(g, b, m, en));
         rchk(adr[7], exp_grp(g, b, m, en));
      end
      $display("test groups done");
      // Core takes the vector; then zero keeps and one clears
      wr(adr[3], 8'hFF);
      wr(adr[2], 8'h02);
      wr(adr[7], 8'h0F);
      ack_en <= 1'b1;
      watch[8] <= ~watch[8];
      repeat (10) @(posedge clk);
      rchk(adr[7], 8'h00);
      @(posedge clk);
      ack_en <= 1'b0;
      watch[8] <= ~watch[8];
      repeat (6) @(posedge clk);
      wr(adr[7], 8'h00);
      rchk(adr[7], 8'h02);
      wr(adr[7], 8'h02);
      rchk(adr[7], 8'h00);
      $display("test clearing done");
      print_verdict();
   end
endmodule
`default_nettype wire
